// >>> hdl/can_transceiver_mode_failsafe.sv
// CAN transceiver digital mode selection and fail-safe control
//
// Behaviour
// - Normal mode: transmit low drives bus dominant
// - Receive output mirrors bus while receiver active
// - Bit rates up to one megabaud
// - Select low, supplies good: Normal mode
// - Select high: Stand-By, driver and receiver off
// - Supplies present: start in Stand-By
// - Inputs pulled high default to Stand-By
// - Mode change completes within mode-change time
// - Under-voltage monitoring active in both modes
// - Long dominant transmit disables bus driver
// - Receiver stays active during dominant time-out
// - Time-out cleared on transmit rising edge or when Normal is no longer requested
// - Under-voltage forces Stand-By regardless of select
// - Under-voltage cleared: follow select input
// - Overheating switches off bus transmitter
// - Driver returns only after cooling with hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "can_xcvr_defs.svh"
module can_transceiver_mode_failsafe #(
    parameter int unsigned TIMEOUT_CYC = `DOM_TIMEOUT_CYC,
    parameter int unsigned MODE_CYC    = `MODE_CHANGE_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Controller side
    input  wire logic tx_data,
    input  wire logic standby_select_n,
    output var  logic rx_data,
    // Supply and thermal monitors
    input  wire logic transceiver_supply_ok,
    input  wire logic logic_supply_ok,
    input  wire logic over_temp,
    input  wire logic temp_below_hyst,
    // Bus front end
    input  wire logic bus_dominant,
    output var  logic bus_drive_dominant,
    output var  logic driver_enable,
    output var  logic receiver_enable,
    output var  logic bus_bias_enable,
    output var  logic undervoltage,
    output var  logic timeout_active,
    output var  logic thermal_shutdown
);
    import can_xcvr_pkg::*;

    localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
    localparam int unsigned MW = $clog2(MODE_CYC + 1);

    // The time-out compare needs two counts and the switch state one
    if (TIMEOUT_CYC < 2 || MODE_CYC < 1) begin : g_bad_counts
        $error("Counts too small");
    end

    typedef struct packed {
        mode_e           mode;
        logic [MW-1:0]   mode_cnt;
        logic [MW-1:0]   sel_cnt;
        logic [CW-1:0]   dom_cnt;
        logic            tx_prev;
        logic            timeout;
        logic            hot;
        logic            uv;
        logic            drv_en;
        logic            rx_en;
        logic            drive_dom;
        logic            rx_out;
    } state_s;

    state_s s_q;
    state_s s_d;

    ////////////////////////////////////////////////////////////////////////////
    logic want_normal;
    logic uv_now;

    always_comb begin
        s_d = s_q;
        // Monitoring active in both modes
        // supply monitoring always
        uv_now = !transceiver_supply_ok || !logic_supply_ok;
        s_d.uv = uv_now;
        want_normal = (standby_select_n == `PIN_LOW) && !uv_now;
        // Run of Normal requests, watched by the mode-change check
        if (!want_normal) begin
            s_d.sel_cnt = '0;
        end else if (s_q.sel_cnt != MW'(MODE_CYC)) begin
            s_d.sel_cnt = s_q.sel_cnt + MW'(1);
        end
        s_d.tx_prev = tx_data;

        if (tx_data == `PIN_HIGH || s_q.tx_prev == `PIN_HIGH) begin
            s_d.dom_cnt = '0;
        end else if (s_q.dom_cnt != CW'(TIMEOUT_CYC)) begin
            s_d.dom_cnt = s_q.dom_cnt + CW'(1);
        end
        // long dominant disables driver
        // Saturated count still trips when Normal is entered late
        if (s_q.mode == MODE_NORMAL && s_q.dom_cnt >= CW'(TIMEOUT_CYC - 1)
            && tx_data == `PIN_LOW) begin
            s_d.timeout = 1'b1;
        end
        if (s_q.timeout && s_q.tx_prev == `PIN_LOW && tx_data == `PIN_HIGH) begin
            s_d.timeout = 1'b0;
        end

        if (over_temp) begin
            s_d.hot = 1'b1;
        end else if (temp_below_hyst) begin
            s_d.hot = 1'b0;
        end

        unique case (s_q.mode)
            MODE_STANDBY: begin
                if (want_normal) begin
                    s_d.mode = MODE_SWITCH;
                    s_d.mode_cnt = MW'(1);
                end
            end
            MODE_SWITCH: begin
                if (!want_normal) begin
                    s_d.mode = MODE_STANDBY;
                end else if (s_q.mode_cnt >= MW'(MODE_CYC)) begin
                    s_d.mode = MODE_NORMAL;
                end else begin
                    s_d.mode_cnt = s_q.mode_cnt + MW'(1);
                end
            end
            MODE_NORMAL: begin
                if (!want_normal) begin
                    s_d.mode = MODE_STANDBY;
                end
            end
        endcase
        if (!want_normal) begin
            s_d.timeout = 1'b0;
        end

        s_d.rx_en = (s_d.mode == MODE_NORMAL);
        s_d.drv_en = s_d.rx_en && !s_d.timeout && !s_d.hot;
        // one-cycle path well under one bit
        s_d.drive_dom = s_d.drv_en && (tx_data == `PIN_LOW);
        s_d.rx_out = s_d.rx_en ? !bus_dominant : `PIN_HIGH;
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset starts in Stand-By
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{mode: MODE_STANDBY, mode_cnt: '0, dom_cnt: '0, tx_prev: 1'b1,
                     timeout: 1'b0, hot: 1'b0, uv: 1'b0, drv_en: 1'b0,
                     rx_en: 1'b0, drive_dom: 1'b0, rx_out: 1'b1, sel_cnt: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_data            = s_q.rx_out;
    assign bus_drive_dominant = s_q.drive_dom;
    assign driver_enable      = s_q.drv_en;
    assign receiver_enable    = s_q.rx_en;
    assign bus_bias_enable    = s_q.rx_en;
    assign undervoltage       = s_q.uv;
    assign timeout_active     = s_q.timeout;
    assign thermal_shutdown   = s_q.hot;

    ////////////////////////////////////////////////////////////////////////////
    sequence seq_select_normal;
        !standby_select_n && transceiver_supply_ok && logic_supply_ok;
    endsequence

    AST_DOMINANT: assert property (@(posedge clk) disable iff (rst)
        driver_enable && !tx_data |-> ##1 (bus_drive_dominant || !driver_enable))
        else $error("Dominant not driven");
    AST_RX_MIRROR: assert property (@(posedge clk) disable iff (rst)
        s_d.rx_en |=> rx_data == !$past(bus_dominant))
        else $error("Receive does not mirror bus");
    AST_NORMAL: assert property (@(posedge clk) disable iff (rst)
        seq_select_normal ##0 (s_q.sel_cnt == MW'(MODE_CYC)) |=> receiver_enable)
        else $error("Normal mode not reached in time");
    AST_STANDBY: assert property (@(posedge clk) disable iff (rst)
        standby_select_n |=> !receiver_enable && !driver_enable)
        else $error("Stand-By not entered");
    AST_UV: assert property (@(posedge clk) disable iff (rst)
        !transceiver_supply_ok || !logic_supply_ok |=> !receiver_enable && undervoltage)
        else $error("Under-voltage did not force Stand-By");
    AST_TIMEOUT_HOLD: assert property (@(posedge clk) disable iff (rst)
        timeout_active && !(($past(tx_data) == 1'b0) && tx_data) && !standby_select_n
        && transceiver_supply_ok && logic_supply_ok |=> timeout_active)
        else $error("Time-out released without rising edge");
    AST_TIMEOUT_RX: assert property (@(posedge clk) disable iff (rst)
        timeout_active |-> !driver_enable && receiver_enable)
        else $error("Time-out state wrong");
    AST_HOT: assert property (@(posedge clk) disable iff (rst)
        over_temp |=> thermal_shutdown && !driver_enable)
        else $error("Overheat did not stop driver");
    AST_RX_IDLE: assert property (@(posedge clk) disable iff (rst)
        !receiver_enable |-> rx_data)
        else $error("Receive not recessive while disabled");
endmodule
`default_nettype wire

// >>> include/can_xcvr_defs.svh
// Constants for the CAN transceiver mode and fail-safe control
`ifndef CAN_XCVR_DEFS_SVH
`define CAN_XCVR_DEFS_SVH
`define CLK_PERIOD_NS      100
`define DOM_TIMEOUT_US     1000
`define DOM_TIMEOUT_CYC    ((`DOM_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define MODE_CHANGE_NS     1000
`define MODE_CHANGE_CYC    ((`MODE_CHANGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_BAUD           1000000
`define MIN_BIT_CYC        ((1000000000 / `MAX_BAUD) / `CLK_PERIOD_NS)
`define PIN_HIGH           1'b1
`define PIN_LOW            1'b0
`endif

// >>> include/can_xcvr_pkg.sv
// Types for the CAN transceiver mode and fail-safe control
package can_xcvr_pkg;
    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_SWITCH,
        MODE_NORMAL
    } mode_e;
endpackage

// >>> testbench/can_ctrl_model.sv
// Controller-side serial transmit model driving the transmit input
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model #(
    parameter int unsigned BIT_CYC = 10
) (
    // Clock
    input  wire logic       clk,
    // Commands
    input  wire logic       send,
    input  wire logic       stuck,
    input  wire logic [7:0] data,
    // Serial output
    output var  logic       tx_data
);
    logic [7:0] sr_q;
    int         cnt_q = 0;
    int         idx;
    ////////////////////////////////////////////////////////////////////////////////
    // bit time floor
    always @(posedge clk) begin
        if (send && cnt_q == 0) begin
            sr_q <= data;
            cnt_q <= 8 * BIT_CYC;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    always_comb begin
        idx = (8 * BIT_CYC - cnt_q) / BIT_CYC;
        tx_data = stuck ? 1'b0 : ((cnt_q != 0) ? sr_q[7 - idx] : 1'b1);
    end
endmodule
`default_nettype wire

// >>> testbench/can_transceiver_mode_failsafe_tb.sv
// Self-checking bench for the transceiver mode and fail-safe block
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_mode_failsafe_tb;
    localparam int TO = 20;
    localparam int MC = 3;
    localparam logic [7:0] PAT = 8'ha5;
    logic clk, rst, tx_data, standby_select_n, rx_data, bus_dominant, ext_dom;
    logic transceiver_supply_ok, logic_supply_ok, over_temp, temp_below_hyst;
    logic bus_drive_dominant, driver_enable, receiver_enable, bus_bias_enable;
    logic undervoltage, timeout_active, thermal_shutdown, send, stuck;
    int   n_errors = 0;
    int   compares = 0;
    // Wired bus: any dominant node wins
    assign bus_dominant = bus_drive_dominant | ext_dom;
    can_transceiver_mode_failsafe #(.TIMEOUT_CYC(TO), .MODE_CYC(MC)) dut (
        .clk(clk), .rst(rst), .tx_data(tx_data), .standby_select_n(standby_select_n),
        .rx_data(rx_data), .transceiver_supply_ok(transceiver_supply_ok),
        .logic_supply_ok(logic_supply_ok), .over_temp(over_temp),
        .temp_below_hyst(temp_below_hyst), .bus_dominant(bus_dominant),
        .bus_drive_dominant(bus_drive_dominant), .driver_enable(driver_enable),
        .receiver_enable(receiver_enable), .bus_bias_enable(bus_bias_enable),
        .undervoltage(undervoltage), .timeout_active(timeout_active),
        .thermal_shutdown(thermal_shutdown));
    can_ctrl_model ctrl (.clk(clk), .send(send), .stuck(stuck), .data(PAT), .tx_data(tx_data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic s, input logic e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic t_normal();
        tick(1);
        standby_select_n <= 1'b0;
        tick(MC + 3);
        #1;
        chk(driver_enable, 1'b1);
        chk(bus_bias_enable, 1'b1);
        tick(1);
        send <= 1'b1;
        tick(1);
        send <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            tick(5);
            #1;
            chk(bus_drive_dominant, !PAT[7 - i]);
            chk(rx_data, PAT[7 - i]);
            tick(5);
        end
    endtask
    task automatic t_timeout();
        tick(1);
        stuck <= 1'b1;
        tick(TO - 5);
        // One recessive cycle must restart the time-out count
        stuck <= 1'b0;
        tick(1);
        stuck <= 1'b1;
        tick(TO - 5);
        #1;
        chk(timeout_active, 1'b0);
        chk(bus_drive_dominant, 1'b1);
        tick(10);
        #1;
        chk(timeout_active, 1'b1);
        chk(bus_drive_dominant, 1'b0);
        tick(1);
        ext_dom <= 1'b1;
        tick(3);
        #1;
        chk(rx_data, 1'b0);
        chk(receiver_enable, 1'b1);
        chk(timeout_active, 1'b1);
        tick(1);
        ext_dom <= 1'b0;
        stuck <= 1'b0;
        tick(3);
        #1;
        chk(timeout_active, 1'b0);
        chk(driver_enable, 1'b1);
    endtask
    task automatic t_uv(input int k);
        tick(1);
        ext_dom <= 1'b1;
        if (k == 0) begin
            transceiver_supply_ok <= 1'b0;
        end else begin
            logic_supply_ok <= 1'b0;
        end
        tick(3);
        #1;
        chk(undervoltage, 1'b1);
        chk(receiver_enable, 1'b0);
        chk(rx_data, 1'b1);
        tick(1);
        transceiver_supply_ok <= 1'b1;
        logic_supply_ok <= 1'b1;
        ext_dom <= 1'b0;
        tick(MC + 3);
        #1;
        chk(undervoltage, 1'b0);
        chk(receiver_enable, 1'b1);
    endtask
    task automatic t_thermal();
        tick(1);
        over_temp <= 1'b1;
        temp_below_hyst <= 1'b0;
        stuck <= 1'b1;
        tick(3);
        #1;
        chk(thermal_shutdown, 1'b1);
        chk(bus_drive_dominant, 1'b0);
        tick(1);
        over_temp <= 1'b0;
        stuck <= 1'b0;
        tick(3);
        #1;
        chk(thermal_shutdown, 1'b1);
        chk(driver_enable, 1'b0);
        tick(1);
        temp_below_hyst <= 1'b1;
        tick(3);
        #1;
        chk(thermal_shutdown, 1'b0);
        chk(driver_enable, 1'b1);
    endtask
    task automatic t_standby();
        tick(1);
        standby_select_n <= 1'b1;
        ext_dom <= 1'b1;
        tick(3);
        #1;
        chk(receiver_enable, 1'b0);
        chk(driver_enable, 1'b0);
        chk(bus_bias_enable, 1'b0);
        chk(rx_data, 1'b1);
        tick(1);
        logic_supply_ok <= 1'b0;
        tick(2);
        #1;
        chk(undervoltage, 1'b1);
        tick(1);
        logic_supply_ok <= 1'b1;
        tick(MC + 3);
        #1;
        chk(undervoltage, 1'b0);
        chk(receiver_enable, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        standby_select_n = 1'b1;
        ext_dom = 1'b0;
        send = 1'b0;
        stuck = 1'b0;
        transceiver_supply_ok = 1'b1;
        logic_supply_ok = 1'b1;
        over_temp = 1'b0;
        temp_below_hyst = 1'b1;
        tick(10);
        rst <= 1'b0;
        // Open inputs read high, so the block must sit in Stand-By
        tick(2);
        #1;
        chk(rx_data, 1'b1);
        chk(receiver_enable, 1'b0);
        chk(driver_enable, 1'b0);
        t_normal();
        t_timeout();
        t_uv(0);
        t_uv(1);
        t_thermal();
        t_standby();
        tick(2);
        complete_run();
    end
endmodule
`default_nettype wire
